// >>> src/nvbac_pkg.sv
// package: register map, field layout and timing constants of the byte store controller
package nvbac_pkg;
   // ****************************************
   // register map (word offsets, byte address)
   // ****************************************
   localparam logic [7:0] NVBAC_OFS_ADDR_LOW  = 8'h00;
   localparam logic [7:0] NVBAC_OFS_ADDR_HIGH = 8'h04;
   localparam logic [7:0] NVBAC_OFS_VALUE     = 8'h08;
   localparam logic [7:0] NVBAC_OFS_CONTROL   = 8'h0c;
   localparam logic [7:0] NVBAC_OFS_STATUS    = 8'h10;
   localparam logic [7:0] NVBAC_OFS_OSCDIV    = 8'h14;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int NVBAC_BIT_READ    = 0;
   localparam int NVBAC_BIT_TRIGGER = 1;
   localparam int NVBAC_BIT_ARM     = 2;
   localparam int NVBAC_BIT_IRQEN   = 3;
   localparam int NVBAC_BIT_MODE_LO = 4;
   localparam int NVBAC_BIT_MODE_HI = 5;

   localparam logic [2:0] NVBAC_ARM_CYCLES   = 3'h4;
   localparam logic [2:0] NVBAC_READ_STALL   = 3'h4;
   localparam logic [2:0] NVBAC_PROG_STALL   = 3'h2;
   localparam logic [7:0] NVBAC_ERASED_VALUE = 8'hff;

   // ****************************************
   // programming times in microseconds
   // ****************************************
   localparam int NVBAC_T_ATOMIC_US = 3400;
   localparam int NVBAC_T_SPLIT_US  = 1800;

   typedef enum logic [1:0] {
      NVBAC_MODE_ATOMIC = 2'b00,
      NVBAC_MODE_ERASE  = 2'b01,
      NVBAC_MODE_WRITE  = 2'b10,
      NVBAC_MODE_RSVD   = 2'b11
   } nvbac_mode_t;

   typedef struct packed {
      logic [7:0]  adr;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] dat;
   } nvbac_wbreq_t;
endpackage

// >>> src/nvbac_store.sv
// byte store memory with registered read data
`timescale 1ns/1ns
module nvbac_store #(
   parameter int AW = 9
) (
   // clock
   input  wire logic          clk,
   input  wire logic          ce,
   // access
   input  wire logic [AW-1:0] addr,
   input  wire logic          wrEn,
   input  wire logic [7:0]    wrData,
   output logic [7:0]         rdData
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (ce) begin
         if (wrEn) begin
            mem[addr] <= wrData;
         end
         rdData <= mem[addr];
      end
   end
endmodule

// >>> src/nvbac_ctrl.sv
// byte store access controller: wishbone registers, arm/trigger, timed programming, stalls
//
// Overview of operation
// - byte store is its own space, every byte read and programmed alone.
// - address, value and control registers reachable over the register bus.
// - a read trigger stalls the processor four clock cycles.
// - a programming trigger stalls the processor two clock cycles.
// - mode zero, trigger within four cycles of arm: erase then write.
// - atomic mode keeps trigger set until erase and write done.
// - no read, erase or write while programming runs.
// - mode 01, trigger within four cycles of arm: erase only.
// - erase-only keeps trigger set until erase done, then clears it.
// - mode 10, trigger within four cycles of arm: write without erase.
// - write-only keeps trigger set until write done, then clears it.
// - programming duration timed from the calibrated oscillator tick.
// - self-timed completion flag software can poll.
// - arm bit clears itself four clock cycles after being set.
// - mode field writes ignored while trigger bit is set.
// - atomic 3.4 ms, erase or write 1.8 ms; mode 11 reserved.
// - ready request output high while enabled and not busy.
`timescale 1ns/1ns
module nvbac_ctrl
   import nvbac_pkg::*;
#(
   parameter int AW          = 9,
   parameter int OSC_KHZ     = 8000,
   parameter int T_ATOMIC_US = NVBAC_T_ATOMIC_US,
   parameter int T_SPLIT_US  = NVBAC_T_SPLIT_US
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // calibrated oscillator tick, asynchronous
   input  wire logic        oscTick,
   // processor side
   output logic             cpuStall,
   output logic             readyIrq
);
   import nvbac_pkg::*;

   // high address byte holds bits from eight up, so fewer than nine bits cannot be served
   initial begin
      if (AW < 9 || AW > 16) $error("nvbac_ctrl: AW out of range");
      if (T_ATOMIC_US < 1 || T_SPLIT_US < 1 || OSC_KHZ < 1) $error("nvbac_ctrl: bad timing");
   end

   // ****************************************
   // programming durations in oscillator ticks
   // ****************************************
   localparam int ATOMIC_TICKS = (T_ATOMIC_US * OSC_KHZ) / 1000;
   localparam int SPLIT_TICKS  = (T_SPLIT_US * OSC_KHZ) / 1000;
   localparam int TW           = $clog2(ATOMIC_TICKS + 1);

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} nvbac_state_t;

   // ****************************************
   // registers
   // ****************************************
   logic [AW-1:0]  addrReg;
   logic [7:0]     valueReg;
   nvbac_mode_t    modeReg;
   logic           irqEnReg;
   logic           armReg;
   logic [2:0]     armCnt_reg;
   logic           busyReg;
   nvbac_state_t   state_reg;
   logic [2:0]     stallCnt_reg;
   logic [TW-1:0]  tickCnt_reg;
   logic           doneReg;
   logic [2:0]     tickSync;
   logic           tickPrev;
   nvbac_wbreq_t   req;

   assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};

   // ****************************************
   // bus decode
   // ****************************************
   wire access   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce;
   wire wrAccess = access & req.we & req.sel[0];
   wire hitLow, hitHigh, hitVal, hitCtl, hitSts;
   assign hitLow  = (req.adr == NVBAC_OFS_ADDR_LOW);
   assign hitHigh = (req.adr == NVBAC_OFS_ADDR_HIGH);
   assign hitVal  = (req.adr == NVBAC_OFS_VALUE);
   assign hitCtl  = (req.adr == NVBAC_OFS_CONTROL);
   assign hitSts  = (req.adr == NVBAC_OFS_STATUS);

   wire wrCtl   = wrAccess & hitCtl;
   wire armSet  = wrCtl & req.dat[NVBAC_BIT_ARM];
   wire trigSet = wrCtl & req.dat[NVBAC_BIT_TRIGGER];
   wire readSet = wrCtl & req.dat[NVBAC_BIT_READ];
   wire idle    = (state_reg == ST_IDLE) & ~busyReg;
   wire progStart = trigSet & armReg & idle;
   wire readStart = readSet & ~trigSet & idle;

   // oscillator tick: three-flop synchroniser, edge when stages two and three agree
   wire tickLvl  = tickSync[2];
   wire tickEdge = tickLvl & ~tickPrev & (tickSync[1] == tickSync[2]);

   // ****************************************
   // store access
   // ****************************************
   logic [7:0] storeRd;
   logic       storeWr;
   logic [7:0] storeWrData;
   logic       progLast;
   assign progLast = (state_reg == ST_PROG) & tickEdge & (tickCnt_reg == TW'(1));
   assign storeWrData = (modeReg == NVBAC_MODE_ERASE) ? NVBAC_ERASED_VALUE :
                        (modeReg == NVBAC_MODE_WRITE) ? (storeRd & valueReg) : valueReg;
   assign storeWr = progLast;

   nvbac_store #(.AW(AW)) u_store (
      .clk    (clk),
      .ce     (ce),
      .addr   (addrReg),
      .wrEn   (storeWr),
      .wrData (storeWrData),
      .rdData (storeRd)
   );

   function automatic logic [TW-1:0] modeTicks(input nvbac_mode_t m);
      modeTicks = (m == NVBAC_MODE_ATOMIC) ? TW'(ATOMIC_TICKS) : TW'(SPLIT_TICKS);
   endfunction

   // ****************************************
   // synchroniser
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tickSync <= 3'h0;
         tickPrev <= 1'b0;
      end else if (ce) begin
         tickSync <= {tickSync[1:0], oscTick};
         if (tickSync[1] == tickSync[2]) begin
            tickPrev <= tickLvl;
         end
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addrReg  <= '0;
         valueReg <= 8'h00;
         modeReg  <= NVBAC_MODE_ATOMIC;
         irqEnReg <= 1'b0;
      end else if (ce) begin
         if (wrAccess & hitLow) begin
            addrReg[7:0] <= req.dat[7:0];
         end
         if (wrAccess & hitHigh && AW > 8) begin
            addrReg[AW-1:8] <= req.dat[AW-9:0];
         end
         if (wrAccess & hitVal) begin
            valueReg <= req.dat[7:0];
         end else if (state_reg == ST_READ && stallCnt_reg == 3'h1) begin
            valueReg <= storeRd;
         end
         if (wrCtl) begin
            irqEnReg <= req.dat[NVBAC_BIT_IRQEN];
            if (!busyReg) begin
               modeReg <= nvbac_mode_t'(req.dat[NVBAC_BIT_MODE_HI:NVBAC_BIT_MODE_LO]);
            end
         end
      end
   end

   // ****************************************
   // arm bit with self clear
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armReg     <= 1'b0;
         armCnt_reg <= 3'h0;
      end else if (ce) begin
         if (armSet) begin
            armReg     <= 1'b1;
            armCnt_reg <= NVBAC_ARM_CYCLES;
         end else if (progStart) begin
            armReg <= 1'b0;
         end else if (armReg) begin
            armCnt_reg <= armCnt_reg - 3'h1;
            if (armCnt_reg == 3'h1) begin
               armReg <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // access sequencer
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         stallCnt_reg <= 3'h0;
         tickCnt_reg  <= '0;
         busyReg      <= 1'b0;
         doneReg      <= 1'b0;
      end else if (ce) begin
         if (stallCnt_reg != 3'h0) begin
            stallCnt_reg <= stallCnt_reg - 3'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (progStart && modeReg != NVBAC_MODE_RSVD) begin
                  stallCnt_reg <= NVBAC_PROG_STALL;
                  tickCnt_reg  <= modeTicks(modeReg);
                  busyReg      <= 1'b1;
                  doneReg      <= 1'b0;
                  state_reg    <= ST_PROG;
               end else if (readStart) begin
                  stallCnt_reg <= NVBAC_READ_STALL;
                  state_reg    <= ST_READ;
               end
            end
            ST_READ: begin
               if (stallCnt_reg == 3'h1) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (tickEdge) begin
                  tickCnt_reg <= tickCnt_reg - TW'(1);
               end
               if (progLast) begin
                  busyReg   <= 1'b0;
                  doneReg   <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // bus answer and outputs
   // ****************************************
   wire [31:0] ctlRead = {26'h0, modeReg, irqEnReg, armReg, busyReg, 1'b0};
   wire [31:0] stsRead = {30'h0, doneReg, busyReg};
   wire [31:0] rdMux;
   assign rdMux = hitLow  ? {24'h0, 8'(addrReg)} :
                  hitHigh ? 32'(addrReg >> 8) :
                  hitVal  ? {24'h0, valueReg} :
                  hitCtl  ? ctlRead :
                  hitSts  ? stsRead : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         cpuStall <= 1'b0;
         readyIrq <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= access;
         wb_dat_o <= access ? rdMux : 32'h0;
         cpuStall <= (stallCnt_reg > 3'h1) | progStart | readStart;
         readyIrq <= irqEnReg & ~busyReg;
      end
   end
endmodule

// >>> sim/nvbac_ctrl_properties.sv
// checker: bus, stall and clock-enable properties of the byte store controller
`timescale 1ns/1ns
module nvbac_ctrl_properties
   import nvbac_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // oscillator tick and processor side
   input wire logic        oscTick,
   input wire logic        cpuStall,
   input wire logic        readyIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************************
   // sequences
   // ****************************************
   sequence sTaken;
      wb_cyc_i && wb_stb_i && ce && !wb_ack_o;
   endsequence
   sequence sLongStall;
      cpuStall [*4];
   endsequence
   // ****************************************
   // properties
   // ****************************************
   a_ack_follows: assert property (sTaken |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > NVBAC_OFS_OSCDIV |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_stall_bound: assert property (sLongStall |=> !cpuStall)
      else $error("stall longer than four cycles");
   a_stall_cause: assert property ($rose(cpuStall) |-> wb_ack_o || $past(wb_ack_o))
      else $error("stall without register access");
   a_ce_freeze: assert property (!ce |=> $stable(cpuStall) && $stable(readyIrq) && $stable(wb_ack_o))
      else $error("outputs moved with clock enable low");
endmodule

bind nvbac_ctrl nvbac_ctrl_properties u_props (
   .clk      (clk),
   .rst      (rst),
   .ce       (ce),
   .wb_cyc_i (wb_cyc_i),
   .wb_stb_i (wb_stb_i),
   .wb_we_i  (wb_we_i),
   .wb_adr_i (wb_adr_i),
   .wb_sel_i (wb_sel_i),
   .wb_dat_i (wb_dat_i),
   .wb_dat_o (wb_dat_o),
   .wb_ack_o (wb_ack_o),
   .oscTick  (oscTick),
   .cpuStall (cpuStall),
   .readyIrq (readyIrq)
);

// >>> sim/tb_nvbac_ctrl.sv
// testbench: register access, programming modes and stalls of the byte store controller
`timescale 1ns/1ns
module tb_nvbac_ctrl;
   import nvbac_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, oscTick = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cpuStall, readyIrq;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] datIn = 32'h0, datOut, q;
   logic [2:0]  stallRun = 3'h0, lastStall = 3'h0;
   int          numErrors = 0, checksDone = 0, cycles = 0, tA, tS, n, tStart = 0;

   // short oscillator scaling keeps programming to a few ticks
   nvbac_ctrl #(.OSC_KHZ(2)) DUT (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datIn), .wb_dat_o(datOut),
      .wb_ack_o(ack), .oscTick(oscTick), .cpuStall(cpuStall), .readyIrq(readyIrq));

   always #2 clk = ~clk;
   // tick period unrelated to the bus clock
   always #11 oscTick = ~oscTick;
   always @(posedge clk) begin
      cycles++;
      if (cpuStall) begin
         stallRun <= stallRun + 3'h1;
      end else if (stallRun != 3'h0) begin
         lastStall <= stallRun;
         stallRun  <= 3'h0;
      end
      if (cycles == 30000) begin
         numErrors++;
         giveVerdict();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checksDone++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // waits for the answer however long; only the cycle ceiling ends a hang
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, sel, datIn} <= {2'b11, w, a, 4'h1, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = datOut;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      wbx(1'b0, a, 32'h0);
      check(q, exp, what);
   endtask
   task automatic busyIs(input logic exp);
      wbx(1'b0, NVBAC_OFS_STATUS, 32'h0);
      check(q[0], exp, "busy");
   endtask
   // arm then trigger, three cycles apart on the bus
   task automatic start(input logic [1:0] m);
      wbx(1'b1, NVBAC_OFS_CONTROL, {26'h0, m, 4'h8});
      wbx(1'b1, NVBAC_OFS_CONTROL, {26'h0, m, 4'hc});
      wbx(1'b1, NVBAC_OFS_CONTROL, {26'h0, m, 4'ha});
      tStart = cycles;
   endtask
   // wait busy clear
   // duration in clock cycles since the trigger, not in polls
   task automatic poll(output int t);
      do begin
         wbx(1'b0, NVBAC_OFS_STATUS, 32'h0);
         t = cycles - tStart;
      end while (q[0] !== 1'b0 && t < 400);
      check(q[0], 1'b0, "busyEnd");
      check(q[1], 1'b1, "doneFlag");
   endtask
   task automatic readBack(input logic [31:0] exp);
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h09);
      repeat (8) @(posedge clk);
      check(lastStall, NVBAC_READ_STALL, "readStall");
      rd(NVBAC_OFS_VALUE, exp, "stored");
   endtask
   task automatic giveVerdict();
      if (numErrors == 0 && checksDone > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************
   // sequence of tests
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, "resetValue");
      wbx(1'b1, 8'h20, 32'hff);
      rd(8'h20, 32'h0, "unmapped");
      wbx(1'b1, NVBAC_OFS_ADDR_HIGH, 32'hff);
      rd(NVBAC_OFS_ADDR_HIGH, 32'h1, "addrHigh");
      wbx(1'b1, NVBAC_OFS_ADDR_LOW, 32'h23);
      wbx(1'b1, NVBAC_OFS_VALUE, 32'ha5);
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h08);
      repeat (2) @(posedge clk);
      check(readyIrq, 1'b1, "irqIdle");
      start(2'b00);
      rd(NVBAC_OFS_CONTROL, 32'h0a, "busyAtomic");
      check(readyIrq, 1'b0, "irqBusy");
      @(posedge clk);
      check(lastStall, NVBAC_PROG_STALL, "progStall");
      // read strobe and mode change while busy must both be dropped
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h19);
      rd(NVBAC_OFS_CONTROL, 32'h0a, "modeLocked");
      rd(NVBAC_OFS_VALUE, 32'ha5, "valueKept");
      poll(tA);
      readBack(32'ha5);
      wbx(1'b1, NVBAC_OFS_VALUE, 32'h3c);
      start(2'b01);
      poll(tS);
      readBack(32'hff);
      // the read strobe above refilled the value register, load it again
      wbx(1'b1, NVBAC_OFS_VALUE, 32'h3c);
      start(2'b10);
      poll(n);
      readBack(32'h3c);
      check(tA > tS, 1'b1, "atomicLonger");
      start(2'b11);
      busyIs(1'b0);
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h0a);
      busyIs(1'b0);
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h0c);
      repeat (6) @(posedge clk);
      wbx(1'b1, NVBAC_OFS_CONTROL, 32'h0a);
      busyIs(1'b0);
      // request held while frozen must wait for the enable
      ce <= 1'b0;
      fork
         wbx(1'b1, NVBAC_OFS_VALUE, 32'h55);
         begin
            repeat (4) @(posedge clk);
            check(ack, 1'b0, "ackFrozen");
            ce <= 1'b1;
         end
      join
      rd(NVBAC_OFS_VALUE, 32'h55, "afterFreeze");
      giveVerdict();
   end
endmodule
